/* tb/host_model.sv */
// Host controller that issues register requests to the load bank
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input wire logic clk_i,
   input wire logic ready_i,
   input wire logic rsp_valid_i,
   input wire logic rsp_ok_i,
   input wire logic [31:0] rsp_data_i,
   output logic valid_o,
   output logic cip_o,
   output logic [7:0] code_o,
   output logic [15:0] addr_o,
   output logic [7:0] count_o,
   output logic [7:0] class_o,
   output logic [7:0] attr_o,
   output logic [31:0] wdata_o
);
   logic [7:0] attr = 8'h05;
   initial {valid_o, cip_o, code_o, addr_o, count_o, class_o, attr_o, wdata_o} = '0;
   // Fields held until the taking edge
   task automatic xfer(input logic c, input logic [7:0] k, input logic [15:0] a, input logic [7:0] n,
      input logic [7:0] cl, input logic [31:0] w, output logic ok, output logic [31:0] d);
      int i;
      @(posedge clk_i);
      valid_o <= 1'b1;
      cip_o <= c;
      code_o <= k;
      addr_o <= a;
      count_o <= n;
      class_o <= cl;
      attr_o <= attr;
      wdata_o <= w;
      i = 0;
      do begin
         @(negedge clk_i);
         i++;
      end while (ready_i !== 1'b1 && i < 20);
      @(posedge clk_i);
      valid_o <= 1'b0;
      // Released address and data fields must not keep the last value
      addr_o <= ~a;
      wdata_o <= ~w;
      i = 0;
      do begin
         @(negedge clk_i);
         i++;
      end while (rsp_valid_i !== 1'b1 && i < 20);
      ok = (rsp_valid_i === 1'b1) ? rsp_ok_i : 1'bx;
      d = rsp_data_i;
   endtask
endmodule // host_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the load configuration bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) cmp(n, e, g)
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic rv, rr, rc, rsv, rok, cok, sto, lk, sr, fg, sa, ra, rs, rh, cop = 1'b0, ccl = 1'b0, stp = 1'b0;
   logic [7:0] kc, cnt, cls, att, keys = '0, keyo;
   logic [15:0] ad, rpi = '0, csz = '0;
   logic [31:0] wd, rsd, gd, sv, lv = '0, rmv = '0;
   logic [2:0] ccnt, slot = '0;
   logic [1:0] wt = '0, ps, so;
   logic [31:0] fm [5];
   logic [15:0] wa [4] = '{16'h8030, 16'h8060, 16'h8080, 16'h80A0};
   logic [15:0] qa [4] = '{16'h8020, 16'h8070, 16'h8090, 16'h80B0};
   int mx [4] = '{1, 1, 3, 2};
   int fail_count = 0, checks_done = 0, cyc = 0, nsoft = 0, nhard = 0;
   integer seed = 32'hC21CDCDC;
   load_config_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(rv), .req_ready_o(rr), .req_cip_i(rc),
      .req_code_i(kc), .req_addr_i(ad), .req_count_i(cnt), .req_class_i(cls), .req_attr_i(att),
      .req_wdata_i(wd), .rsp_valid_o(rsv), .rsp_ok_o(rok), .rsp_data_o(rsd), .conn_open_i(cop),
      .conn_close_i(ccl), .conn_rpi_i(rpi), .conn_size_i(csz), .conn_ok_o(cok), .conn_count_o(ccnt),
      .waveform_type_i(wt), .gen_slot_i(slot), .gen_data_o(gd), .local_volt_i(lv), .remote_volt_i(rmv),
      .sensed_volt_o(sv), .panel_keys_i(keys), .panel_stop_i(stp), .keys_o(keyo), .stop_o(sto),
      .panel_lock_o(lk), .sense_remote_o(sr), .protocol_select_o(ps), .setpoint_origin_o(so),
      .fgen_run_o(fg), .step_active_o(sa), .ramp_active_o(ra), .restore_soft_o(rs), .restore_hard_o(rh));
   host_model host (.clk_i(clk_i), .ready_i(rr), .rsp_valid_i(rsv), .rsp_ok_i(rok), .rsp_data_i(rsd),
      .valid_o(rv), .cip_o(rc), .code_o(kc), .addr_o(ad), .count_o(cnt), .class_o(cls), .attr_o(att),
      .wdata_o(wd));
   initial forever #5 clk_i = ~clk_i;
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Ceiling well above the few hundred cycles the sequence needs
   always @(posedge clk_i) begin
      cyc++;
      nsoft += int'(rs === 1'b1);
      nhard += int'(rh === 1'b1);
      if (cyc == 20000) begin
         fail_count++;
         summarize();
      end
   end
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rq(input logic c, input logic [7:0] k, input logic [15:0] a, input logic [7:0] n,
      input logic [31:0] w, input logic eo, input logic [31:0] ed, input logic [7:0] cl = 8'hA2);
      logic ok;
      logic [31:0] d;
      host.xfer(c, k, a, n, cl, w, ok, d);
      `CHK("rsp_ok", {31'h0, eo}, {31'h0, ok});
      `CHK("rsp_data", ed, d);
   endtask
   function automatic logic [31:0] sw(input logic [31:0] v);
      return {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction
   // Levels floor at zero, durations held to 2.0 .. 65000.0
   function automatic logic [31:0] clp(input int s, input logic [31:0] v);
      if (s < 3) return v[31] ? 32'h0 : v;
      if (v[31] || v < 32'h40000000) return 32'h40000000;
      return (v > 32'h477DE800) ? 32'h477DE800 : v;
   endfunction
   function automatic logic [31:0] pv(input int j);
      logic [1:0] r [4];
      r = '{{1'b0, lk}, {1'b0, sr}, ps, so};
      return {30'h0, r[j]};
   endfunction
   initial begin
      logic [31:0] v;
      logic [31:0] tb [6];
      logic [15:0] a;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      `CHK("reset_cfg", 32'h8, {26'h0, lk, sr, ps, so});
      for (int i = 0; i < 5; i++) begin
         a = 16'h7130 + 16'(i * 32);
         v = $random(seed) & 32'hCFFFFFFF;
         fm[i] = clp(i, v);
         rq(0, 8'h10, a, 8'h02, v, 1, 0);
         rq(0, 8'h03, a + 16'h10, 8'h02, 0, 1, fm[i]);
         @(posedge clk_i);
         slot <= 3'(i);
         repeat (2) @(negedge clk_i);
         `CHK("gen_data", fm[i], gd);
      end
      tb = '{32'h3FFFFFFF, 32'h40000000, 32'h477DE800, 32'h477DE801, 32'hC0000000, 32'h00000001};
      for (int j = 0; j < 6; j++) begin
         a = 16'h7190 + 16'((j % 2) * 32);
         rq(0, 8'h10, a, 8'h02, tb[j], 1, 0);
         rq(0, 8'h03, a + 16'h10, 8'h02, 0, 1, clp(3, tb[j]));
      end
      rq(0, 8'h10, 16'h7130, 8'h01, 32'h3F800000, 0, 0);
      rq(0, 8'h03, 16'h7140, 8'h02, 0, 1, fm[0]);
      rq(0, 8'h03, 16'h7000, 8'h02, 0, 0, 0);
      rq(0, 8'h03, 16'h7130, 8'h02, 0, 0, 0);
      rq(0, 8'h03, 16'h8010, 8'h01, 0, 0, 0);
      rq(0, 8'h04, 16'h7140, 8'h02, 0, 0, 0);
      v = $random(seed) & 32'h4FFFFFFF;
      rq(1, 8'h10, 16'h7150, 0, sw(v), 1, 0);
      rq(1, 8'h0E, 16'h7160, 0, 0, 1, sw(v));
      rq(1, 8'h0E, 16'h7160, 0, 0, 0, 0, 8'hA1);
      rq(1, 8'h01, 16'h7160, 0, 0, 0, 0);
      rq(1, 8'h10, 16'h7160, 0, sw(v), 0, 0);
      host.attr = 8'h01;
      rq(1, 8'h0E, 16'h7150, 0, 0, 1, sw(32'h7150));
      host.attr = 8'h04;
      rq(1, 8'h0E, 16'h7160, 0, 0, 1, sw(1));
      rq(1, 8'h0E, 16'h8030, 0, 0, 1, sw(2));
      host.attr = 8'h05;
      for (int j = 0; j < 4; j++) begin
         for (int c = 0; c <= mx[j] + 1; c++) begin
            rq(0, 8'h06, wa[j], 8'h01, 32'(c), c <= mx[j], 0);
            rq(0, 8'h03, qa[j], 8'h01, 0, 1, 32'(c > mx[j] ? mx[j] : c));
            @(negedge clk_i);
            `CHK("cfg_port", 32'(c > mx[j] ? mx[j] : c), pv(j));
            `CHK("fgen_run", {31'h0, j == 3 && c == 1}, {31'h0, fg});
         end
      end
      @(posedge clk_i);
      keys <= 8'($random(seed)) | 8'h01;
      stp <= 1'b1;
      lv <= $random(seed);
      rmv <= $random(seed);
      repeat (5) @(negedge clk_i);
      `CHK("keys_locked", 0, {24'h0, keyo});
      `CHK("stop", 1, {31'h0, sto});
      `CHK("sensed_remote", rmv, sv);
      rq(0, 8'h06, 16'h8030, 8'h01, 0, 1, 0);
      repeat (5) @(negedge clk_i);
      `CHK("keys_free", {24'h0, keys}, {24'h0, keyo});
      rq(0, 8'h06, 16'h80A0, 8'h01, 1, 1, 0);
      for (int t = 0; t < 4; t++) begin
         @(posedge clk_i);
         wt <= 2'(t);
         repeat (3) @(negedge clk_i);
         `CHK("wave_act", {30'h0, t == 2, t == 3}, {30'h0, sa, ra});
      end
      rq(0, 8'h06, 16'h8010, 8'h01, 3, 0, 0);
      rq(0, 8'h06, 16'h8010, 8'h01, 1, 1, 0);
      repeat (2) @(negedge clk_i);
      `CHK("soft_cfg", 32'h8, {26'h0, lk, sr, ps, so});
      `CHK("soft_pulse", 1, nsoft);
      `CHK("sensed_local", lv, sv);
      rq(0, 8'h03, 16'h7140, 8'h02, 0, 1, fm[0]);
      rq(0, 8'h06, 16'h8010, 8'h01, 2, 1, 0);
      rq(0, 8'h03, 16'h7140, 8'h02, 0, 1, 0);
      `CHK("hard_pulse", 1, nhard);
      for (int k = 0; k < 10; k++) begin
         @(posedge clk_i);
         cop <= 1'b1;
         rpi <= k == 0 ? 16'h0063 : k == 1 ? 16'h2711 : k[0] ? 16'h0064 : 16'h2710;
         csz <= k == 2 ? 16'h05F7 : 16'h05F6;
         @(negedge clk_i);
         `CHK("conn_ok", {31'h0, k > 2 && k < 9}, {31'h0, cok});
         @(posedge clk_i);
         cop <= 1'b0;
      end
      @(negedge clk_i);
      `CHK("conn_cnt", 6, {29'h0, ccnt});
      for (int k = 0; k < 7; k++) begin
         @(posedge clk_i);
         ccl <= 1'b1;
         @(posedge clk_i);
         ccl <= 1'b0;
      end
      @(negedge clk_i);
      `CHK("conn_cnt0", 0, {29'h0, ccnt});
      summarize();
   end
endmodule // tb_top
`default_nettype wire

/* verilog/load_cfg_map.svh */
// Register offsets, command codes and reset values of the load configuration bank
`ifndef LOAD_CFG_MAP_SVH
`define LOAD_CFG_MAP_SVH
`define STEP_UPPER_LEVEL_WR 16'h7130
`define STEP_UPPER_LEVEL_RD 16'h7140
`define RAMP_LOWER_LEVEL_WR 16'h7150
`define RAMP_LOWER_LEVEL_RD 16'h7160
`define RAMP_UPPER_LEVEL_WR 16'h7170
`define RAMP_UPPER_LEVEL_RD 16'h7180
`define RAMP_RISE_TIME_WR 16'h7190
`define RAMP_RISE_TIME_RD 16'h71A0
`define RAMP_FALL_TIME_WR 16'h71B0
`define RAMP_FALL_TIME_RD 16'h71C0
`define DEFAULTS_RESTORE_CMD 16'h8010
`define PANEL_LOCK_RD 16'h8020
`define PANEL_LOCK_WR 16'h8030
`define SENSE_LOCATION_WR 16'h8060
`define SENSE_LOCATION_RD 16'h8070
`define PROTOCOL_SELECT_WR 16'h8080
`define PROTOCOL_SELECT_RD 16'h8090
`define SETPOINT_ORIGIN_WR 16'h80A0
`define SETPOINT_ORIGIN_RD 16'h80B0
`define SLOT_STEP_UPPER 3'h0
`define SLOT_RAMP_LOWER 3'h1
`define SLOT_RAMP_UPPER 3'h2
`define SLOT_RAMP_RISE 3'h3
`define SLOT_RAMP_FALL 3'h4
`define MB_READ_HOLDING 8'h03
`define MB_WRITE_SINGLE 8'h06
`define MB_WRITE_MULTI 8'h10
`define MB_COUNT_FLOAT 8'h02
`define MB_COUNT_SHORT 8'h01
`define CIP_GET_SINGLE 8'h0E
`define CIP_SET_SINGLE 8'h10
`define CIP_CLASS_ID 8'hA2
`define CIP_ATTR_NAME 8'h01
`define CIP_ATTR_ACCESS 8'h04
`define CIP_ATTR_VALUE 8'h05
`define CIP_ACCESS_READ 32'h00000001
`define CIP_ACCESS_WRITE 32'h00000002
`define RESTORE_SOFT 16'h0001
`define RESTORE_HARD 16'h0002
`define PROTOCOL_MAX 16'h0003
`define ORIGIN_MAX 16'h0002
`define ORIGIN_FUNC_GEN 2'h1
`define WAVE_STEP 2'h2
`define WAVE_RAMP 2'h3
`define LOCK_RESET 1'b0
`define SENSE_RESET 1'b0
`define PROTOCOL_RESET 2'h2
`define ORIGIN_RESET 2'h0
// 2.0 and 65000.0 as single-precision floats, duration bounds in ms
`define DURATION_MIN_F 32'h40000000
`define DURATION_MAX_F 32'h477DE800
`define RPI_MIN_MS 16'h0064
`define RPI_MAX_MS 16'h2710
`endif

/* verilog/load_cfg_pkg.sv */
// Types shared by the load configuration bank
package load_cfg_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_FETCH = 2'b11,
      ST_REPLY = 2'b10
   } xact_state_e;
   typedef enum logic [3:0] {
      K_NONE, K_FLOAT_WR, K_FLOAT_RD, K_RESTORE, K_LOCK_WR, K_LOCK_RD,
      K_SENSE_WR, K_SENSE_RD, K_PROT_WR, K_PROT_RD, K_ORIG_WR, K_ORIG_RD
   } reg_kind_e;
   typedef struct packed {
      reg_kind_e kind;
      logic [2:0] slot;
   } reg_hit_s;
endpackage

/* verilog/load_config_regs.sv */
// Host-reachable configuration and waveform parameter bank of the electronic load
//
// Behaviour
// - Two-register float write with code 0x10 sets step upper level.
// - Two-register float write sets ramp lower level.
// - Two-register float write sets ramp upper level.
// - Ramp rise time stored in ms, held within 2 to 65000 ms.
// - Ramp fall time stored in ms, same bounded range.
// - Read code 0x03 with two registers at query address returns stored float.
// - Single write of 1 gives soft restore, 2 hard restore; no query.
// - Writing 1 locks, 0 unlocks; locked panel keeps only stop working.
// - Sense at terminals for 0, remote terminal for 1; feeds power math.
// - Protocol code 0 to 3 switches the command protocol.
// - Set-point origin code 0 local, 1 generator, 2 analog input.
// - Generator drives set points only while origin is the generator code.
// - Explicit messages use only get-single and set-single services.
// - Attributes name 1, access 4 and value 5 exist per instance.
// - Every explicit request gets a success or failure answer.
// - Up to six connections, interval 100 to 10000 ms.
// - Connections accepted up to 1526 bytes, point to point.
// - Device only answers; it never starts a transaction.
// - Waveform codes 0 sine, 1 square, 2 step, 3 ramp pick parameters.
// - 32-bit values in explicit messages travel least significant byte first.
`timescale 1ns/100ps
`default_nettype none
`include "load_cfg_map.svh"
module load_config_regs #(
   parameter int MAX_CONN = 6,
   parameter int MAX_CONN_BYTES = 1526,
   parameter int KEYS = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic req_cip_i,
   input wire logic [7:0] req_code_i,
   input wire logic [15:0] req_addr_i,
   input wire logic [7:0] req_count_i,
   input wire logic [7:0] req_class_i,
   input wire logic [7:0] req_attr_i,
   input wire logic [31:0] req_wdata_i,
   output logic rsp_valid_o,
   output logic rsp_ok_o,
   output logic [31:0] rsp_data_o,
   input wire logic conn_open_i,
   input wire logic conn_close_i,
   input wire logic [15:0] conn_rpi_i,
   input wire logic [15:0] conn_size_i,
   output logic conn_ok_o,
   output logic [2:0] conn_count_o,
   input wire logic [1:0] waveform_type_i,
   input wire logic [2:0] gen_slot_i,
   output logic [31:0] gen_data_o,
   input wire logic [31:0] local_volt_i,
   input wire logic [31:0] remote_volt_i,
   output logic [31:0] sensed_volt_o,
   input wire logic [KEYS-1:0] panel_keys_i,
   input wire logic panel_stop_i,
   output logic [KEYS-1:0] keys_o,
   output logic stop_o,
   output logic panel_lock_o,
   output logic sense_remote_o,
   output logic [1:0] protocol_select_o,
   output logic [1:0] setpoint_origin_o,
   output logic fgen_run_o,
   output logic step_active_o,
   output logic ramp_active_o,
   output logic restore_soft_o,
   output logic restore_hard_o
);
   import load_cfg_pkg::*;

   xact_state_e state;
   logic r_cip;
   logic [7:0] r_code;
   logic [15:0] r_addr;
   logic [7:0] r_count;
   logic [7:0] r_class;
   logic [7:0] r_attr;
   logic [31:0] r_wdata;
   logic r_ok;
   reg_hit_s hit;
   logic is_float, wr_kind, rd_kind, val_ok, want_wr, want_rd, path_ok, wr_ok, rd_ok;
   logic [15:0] val16;
   logic [31:0] rd_word;
   logic [31:0] mem_rdata;
   logic mem_we, mem_clear;
   logic [KEYS-1:0] keys_meta, keys_sync;
   logic [1:0] stop_sync;
   logic taken;

   function automatic reg_hit_s decode_addr(input logic [15:0] a);
      reg_hit_s h;
      h = '{K_NONE, 3'h0};
      if (a == `STEP_UPPER_LEVEL_WR) h = '{K_FLOAT_WR, `SLOT_STEP_UPPER};
      else if (a == `STEP_UPPER_LEVEL_RD) h = '{K_FLOAT_RD, `SLOT_STEP_UPPER};
      else if (a == `RAMP_LOWER_LEVEL_WR) h = '{K_FLOAT_WR, `SLOT_RAMP_LOWER};
      else if (a == `RAMP_LOWER_LEVEL_RD) h = '{K_FLOAT_RD, `SLOT_RAMP_LOWER};
      else if (a == `RAMP_UPPER_LEVEL_WR) h = '{K_FLOAT_WR, `SLOT_RAMP_UPPER};
      else if (a == `RAMP_UPPER_LEVEL_RD) h = '{K_FLOAT_RD, `SLOT_RAMP_UPPER};
      else if (a == `RAMP_RISE_TIME_WR) h = '{K_FLOAT_WR, `SLOT_RAMP_RISE};
      else if (a == `RAMP_RISE_TIME_RD) h = '{K_FLOAT_RD, `SLOT_RAMP_RISE};
      else if (a == `RAMP_FALL_TIME_WR) h = '{K_FLOAT_WR, `SLOT_RAMP_FALL};
      else if (a == `RAMP_FALL_TIME_RD) h = '{K_FLOAT_RD, `SLOT_RAMP_FALL};
      else if (a == `DEFAULTS_RESTORE_CMD) h = '{K_RESTORE, 3'h0};
      else if (a == `PANEL_LOCK_WR) h = '{K_LOCK_WR, 3'h0};
      else if (a == `PANEL_LOCK_RD) h = '{K_LOCK_RD, 3'h0};
      else if (a == `SENSE_LOCATION_WR) h = '{K_SENSE_WR, 3'h0};
      else if (a == `SENSE_LOCATION_RD) h = '{K_SENSE_RD, 3'h0};
      else if (a == `PROTOCOL_SELECT_WR) h = '{K_PROT_WR, 3'h0};
      else if (a == `PROTOCOL_SELECT_RD) h = '{K_PROT_RD, 3'h0};
      else if (a == `SETPOINT_ORIGIN_WR) h = '{K_ORIG_WR, 3'h0};
      else if (a == `SETPOINT_ORIGIN_RD) h = '{K_ORIG_RD, 3'h0};
      return h;
   endfunction

   // Positive floats order like unsigned integers, so bounds compare as bits
   function automatic logic [31:0] clamp_value(input logic [2:0] slot, input logic [31:0] v);
      logic [31:0] c;
      c = v;
      if (slot >= `SLOT_RAMP_RISE) begin
         if (v[31] || v < `DURATION_MIN_F) c = `DURATION_MIN_F;
         else if (v > `DURATION_MAX_F) c = `DURATION_MAX_F;
      end else if (v[31]) begin
         c = 32'h00000000;
      end
      return c;
   endfunction

   function automatic logic [31:0] swap_bytes(input logic [31:0] v);
      return {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction

   assign taken = req_valid_i && req_ready_o;
   assign req_ready_o = (state == ST_IDLE);
   assign rsp_valid_o = (state == ST_REPLY);

   // Answers only follow a taken request; nothing is ever sent unprompted
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: if (req_valid_i) state <= ST_EXEC;
            ST_EXEC: state <= ST_FETCH;
            ST_FETCH: state <= ST_REPLY;
            default: state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_cip <= 1'b0;
         r_code <= 8'h00;
         r_addr <= 16'h0000;
         r_count <= 8'h00;
         r_class <= 8'h00;
         r_attr <= 8'h00;
         r_wdata <= 32'h00000000;
      end else if (taken) begin
         r_cip <= req_cip_i;
         r_code <= req_code_i;
         r_addr <= req_addr_i;
         r_count <= req_count_i;
         r_class <= req_class_i;
         r_attr <= req_attr_i;
         r_wdata <= req_cip_i ? swap_bytes(req_wdata_i) : req_wdata_i;
      end
   end

   always_comb begin
      hit = decode_addr(r_addr);
      val16 = r_wdata[15:0];
      is_float = (hit.kind == K_FLOAT_WR) || (hit.kind == K_FLOAT_RD);
      wr_kind = hit.kind inside {K_FLOAT_WR, K_RESTORE, K_LOCK_WR, K_SENSE_WR, K_PROT_WR, K_ORIG_WR};
      rd_kind = hit.kind inside {K_FLOAT_RD, K_LOCK_RD, K_SENSE_RD, K_PROT_RD, K_ORIG_RD};
      path_ok = !r_cip || (r_class == `CIP_CLASS_ID);
      if (r_cip) begin
         want_wr = (r_code == `CIP_SET_SINGLE) && (r_attr == `CIP_ATTR_VALUE);
         want_rd = (r_code == `CIP_GET_SINGLE) && (r_attr inside {`CIP_ATTR_NAME, `CIP_ATTR_ACCESS,
            `CIP_ATTR_VALUE});
      end else begin
         want_wr = (r_code == (is_float ? `MB_WRITE_MULTI : `MB_WRITE_SINGLE))
            && (r_count == (is_float ? `MB_COUNT_FLOAT : `MB_COUNT_SHORT));
         want_rd = (r_code == `MB_READ_HOLDING)
            && (r_count == (is_float ? `MB_COUNT_FLOAT : `MB_COUNT_SHORT));
      end
      case (hit.kind)
         K_RESTORE: val_ok = (val16 == `RESTORE_SOFT) || (val16 == `RESTORE_HARD);
         K_LOCK_WR, K_SENSE_WR: val_ok = (val16 <= 16'h0001);
         K_PROT_WR: val_ok = (val16 <= `PROTOCOL_MAX);
         K_ORIG_WR: val_ok = (val16 <= `ORIGIN_MAX);
         default: val_ok = 1'b1;
      endcase
      wr_ok = path_ok && want_wr && wr_kind && val_ok;
      // Name and access attributes exist on every instance, value only on readable ones
      rd_ok = path_ok && want_rd && (r_attr != `CIP_ATTR_VALUE && r_cip ? hit.kind != K_NONE : rd_kind);
   end

   assign mem_we = (state == ST_EXEC) && wr_ok && (hit.kind == K_FLOAT_WR);
   assign mem_clear = restore_hard_o;

   param_store #(.WIDTH(32), .DEPTH(5), .AW(3)) u_store (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clear_i(mem_clear),
      .we_i(mem_we),
      .waddr_i(hit.slot),
      .wdata_i(clamp_value(hit.slot, r_wdata)),
      .raddr_i(hit.slot),
      .rdata_o(mem_rdata),
      .gen_addr_i(gen_slot_i),
      .gen_data_o(gen_data_o)
   );

   // Restore takes effect one cycle after the command, so a write beside it cannot race
   always_ff @(posedge clk_i) begin
      if (rst_i || restore_soft_o || restore_hard_o) begin
         panel_lock_o <= `LOCK_RESET;
         sense_remote_o <= `SENSE_RESET;
         protocol_select_o <= `PROTOCOL_RESET;
         setpoint_origin_o <= `ORIGIN_RESET;
      end else if (state == ST_EXEC && wr_ok) begin
         if (hit.kind == K_LOCK_WR) panel_lock_o <= val16[0];
         if (hit.kind == K_SENSE_WR) sense_remote_o <= val16[0];
         if (hit.kind == K_PROT_WR) protocol_select_o <= val16[1:0];
         if (hit.kind == K_ORIG_WR) setpoint_origin_o <= val16[1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         restore_soft_o <= 1'b0;
         restore_hard_o <= 1'b0;
      end else begin
         restore_soft_o <= (state == ST_EXEC) && wr_ok && (hit.kind == K_RESTORE) && (val16 == `RESTORE_SOFT);
         restore_hard_o <= (state == ST_EXEC) && wr_ok && (hit.kind == K_RESTORE) && (val16 == `RESTORE_HARD);
      end
   end

   always_comb begin
      rd_word = 32'h00000000;
      if (r_cip && r_attr == `CIP_ATTR_NAME) rd_word = {16'h0000, r_addr};
      else if (r_cip && r_attr == `CIP_ATTR_ACCESS) rd_word = rd_kind ? `CIP_ACCESS_READ : `CIP_ACCESS_WRITE;
      else if (hit.kind == K_FLOAT_RD) rd_word = mem_rdata;
      else if (hit.kind == K_LOCK_RD) rd_word = {31'h0, panel_lock_o};
      else if (hit.kind == K_SENSE_RD) rd_word = {31'h0, sense_remote_o};
      else if (hit.kind == K_PROT_RD) rd_word = {30'h0, protocol_select_o};
      else if (hit.kind == K_ORIG_RD) rd_word = {30'h0, setpoint_origin_o};
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_ok <= 1'b0;
         rsp_ok_o <= 1'b0;
         rsp_data_o <= 32'h00000000;
      end else if (state == ST_EXEC) begin
         r_ok <= wr_ok || rd_ok;
      end else if (state == ST_FETCH) begin
         rsp_ok_o <= r_ok;
         rsp_data_o <= (r_ok && !want_wr) ? (r_cip ? swap_bytes(rd_word) : rd_word) : 32'h00000000;
      end
   end

   // Only point-to-point explicit connections are tracked here
   assign conn_ok_o = conn_open_i && (int'(conn_count_o) < MAX_CONN)
      && (conn_rpi_i >= `RPI_MIN_MS) && (conn_rpi_i <= `RPI_MAX_MS)
      && (int'(conn_size_i) <= MAX_CONN_BYTES);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conn_count_o <= 3'h0;
      end else if (conn_ok_o && !(conn_close_i && conn_count_o != 3'h0)) begin
         conn_count_o <= conn_count_o + 3'h1;
      end else if (!conn_ok_o && conn_close_i && conn_count_o != 3'h0) begin
         conn_count_o <= conn_count_o - 3'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fgen_run_o <= 1'b0;
         step_active_o <= 1'b0;
         ramp_active_o <= 1'b0;
         sensed_volt_o <= 32'h00000000;
      end else begin
         fgen_run_o <= (setpoint_origin_o == `ORIGIN_FUNC_GEN);
         step_active_o <= (setpoint_origin_o == `ORIGIN_FUNC_GEN) && (waveform_type_i == `WAVE_STEP);
         ramp_active_o <= (setpoint_origin_o == `ORIGIN_FUNC_GEN) && (waveform_type_i == `WAVE_RAMP);
         sensed_volt_o <= sense_remote_o ? remote_volt_i : local_volt_i;
      end
   end

   // Panel pins are asynchronous; two stages before the lock gate looks at them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         keys_meta <= '0;
         keys_sync <= '0;
         stop_sync <= 2'b00;
         keys_o <= '0;
         stop_o <= 1'b0;
      end else begin
         keys_meta <= panel_keys_i;
         keys_sync <= keys_meta;
         stop_sync <= {stop_sync[0], panel_stop_i};
         keys_o <= panel_lock_o ? '0 : keys_sync;
         stop_o <= stop_sync[1];
      end
   end

   property p_reply_latency;
      @(posedge clk_i) disable iff (rst_i) taken |-> !rsp_valid_o ##3 rsp_valid_o;
   endproperty
   a_reply_latency: assert property (p_reply_latency) else $error("answer not three cycles after request");
   property p_no_unsolicited;
      @(posedge clk_i) disable iff (rst_i) rsp_valid_o |-> $past(taken, 3);
   endproperty
   a_no_unsolicited: assert property (p_no_unsolicited) else $error("answer without a request");
   property p_lock_gate;
      @(posedge clk_i) disable iff (rst_i) panel_lock_o && $past(panel_lock_o) |-> keys_o == '0;
   endproperty
   a_lock_gate: assert property (p_lock_gate) else $error("panel key passed while locked");
   property p_origin_write;
      @(posedge clk_i) disable iff (rst_i)
         taken && !req_cip_i && req_code_i == `MB_WRITE_SINGLE && req_count_i == `MB_COUNT_SHORT
         && req_addr_i == `SETPOINT_ORIGIN_WR && req_wdata_i[15:0] == 16'h0001 |-> ##3 fgen_run_o;
   endproperty
   a_origin_write: assert property (p_origin_write) else $error("generator not enabled by origin write");
   property p_rise_bound;
      @(posedge clk_i) disable iff (rst_i) rsp_valid_o && rsp_ok_o && !r_cip && r_addr == `RAMP_RISE_TIME_RD
         && |rsp_data_o |-> rsp_data_o >= `DURATION_MIN_F && rsp_data_o <= `DURATION_MAX_F;
   endproperty
   a_rise_bound: assert property (p_rise_bound) else $error("rise time out of range");
   property p_fall_bound;
      @(posedge clk_i) disable iff (rst_i) rsp_valid_o && rsp_ok_o && !r_cip && r_addr == `RAMP_FALL_TIME_RD
         && |rsp_data_o |-> rsp_data_o >= `DURATION_MIN_F && rsp_data_o <= `DURATION_MAX_F;
   endproperty
   a_fall_bound: assert property (p_fall_bound) else $error("fall time out of range");
   property p_sense_mux;
      @(posedge clk_i) disable iff (rst_i)
         ##1 sensed_volt_o == ($past(sense_remote_o) ? $past(remote_volt_i) : $past(local_volt_i));
   endproperty
   a_sense_mux: assert property (p_sense_mux) else $error("sensed voltage from wrong point");
   property p_conn_limit;
      @(posedge clk_i) disable iff (rst_i) conn_ok_o |-> int'(conn_size_i) <= MAX_CONN_BYTES
         ##1 int'(conn_count_o) <= MAX_CONN;
   endproperty
   a_conn_limit: assert property (p_conn_limit) else $error("connection accepted beyond limits");
   property p_cip_service;
      @(posedge clk_i) disable iff (rst_i) rsp_valid_o && rsp_ok_o && r_cip
         |-> r_code inside {`CIP_GET_SINGLE, `CIP_SET_SINGLE};
   endproperty
   a_cip_service: assert property (p_cip_service) else $error("unsupported service answered ok");
   property p_hard_restore;
      @(posedge clk_i) disable iff (rst_i) restore_hard_o |=> !panel_lock_o && setpoint_origin_o == `ORIGIN_RESET;
   endproperty
   a_hard_restore: assert property (p_hard_restore) else $error("restore left settings changed");

   c_float_write: cover property (@(posedge clk_i) mem_we);
   c_cip_get: cover property (@(posedge clk_i) rsp_valid_o && rsp_ok_o && r_cip && r_code == 8'h0E);
   c_conn_refused: cover property (@(posedge clk_i) conn_open_i && !conn_ok_o);
   c_locked: cover property (@(posedge clk_i) panel_lock_o && keys_sync != '0);
endmodule // load_config_regs
`default_nettype wire

/* verilog/param_store.sv */
// Small waveform parameter memory with a host and a generator read port
`timescale 1ns/100ps
`default_nettype none
module param_store #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 5,
   parameter int AW = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic clear_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [WIDTH-1:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [WIDTH-1:0] rdata_o,
   input wire logic [AW-1:0] gen_addr_i,
   output logic [WIDTH-1:0] gen_data_o
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
      end else if (we_i && int'(waddr_i) < DEPTH) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   // Out-of-range addresses read zero rather than an undefined word
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= '0;
         gen_data_o <= '0;
      end else begin
         rdata_o <= (int'(raddr_i) < DEPTH) ? mem[raddr_i] : '0;
         gen_data_o <= (int'(gen_addr_i) < DEPTH) ? mem[gen_addr_i] : '0;
      end
   end
endmodule // param_store
`default_nettype wire
